/* File: verilog/fault_flag_pkg.sv */
package fault_flag_pkg;

    // ========================================================================
    // Register indexes (byte address is four times the index)
    localparam logic [15:0] IDX_CHAN_B_OV     = 16'hfe27;
    localparam logic [15:0] IDX_CHAN_A_UV     = 16'hfe28;
    localparam logic [15:0] IDX_CHAN_B_UV     = 16'hfe29;
    localparam logic [15:0] IDX_FAULT_STATUS  = 16'hfe80;
    localparam logic [15:0] IDX_FAULT_MASK    = 16'hfe81;
    localparam logic [15:0] IDX_FAULT_LIVE    = 16'hfe82;

    localparam int          ADDR_W            = 18;
    localparam logic [17:0] ADDR_CHAN_B_OV    = {IDX_CHAN_B_OV, 2'b00};
    localparam logic [17:0] ADDR_CHAN_A_UV    = {IDX_CHAN_A_UV, 2'b00};
    localparam logic [17:0] ADDR_CHAN_B_UV    = {IDX_CHAN_B_UV, 2'b00};
    localparam logic [17:0] ADDR_FAULT_STATUS = {IDX_FAULT_STATUS, 2'b00};
    localparam logic [17:0] ADDR_FAULT_MASK   = {IDX_FAULT_MASK, 2'b00};
    localparam logic [17:0] ADDR_FAULT_LIVE   = {IDX_FAULT_LIVE, 2'b00};

    // ========================================================================
    // Field layout and reset values
    localparam int          OV_DEB_HI         = 7;
    localparam int          OV_DEB_LO         = 6;
    localparam int          OV_CODE_W         = 6;
    localparam int          UV_DEB_BIT        = 7;
    localparam int          UV_THR_W          = 7;
    localparam int          NUM_FLAGS         = 3;
    localparam int          BIT_CHAN_B_OV     = 0;
    localparam int          BIT_CHAN_A_UV     = 1;
    localparam int          BIT_CHAN_B_UV     = 2;
    localparam logic [7:0]  RST_SETTING       = 8'h00;
    localparam logic [2:0]  RST_MASK          = 3'h0;
    localparam logic [1:0]  OV_DEB_NONE       = 2'h0;
    localparam logic [1:0]  OV_DEB_SHORT      = 2'h1;
    localparam logic [1:0]  OV_DEB_MID        = 2'h2;
    localparam logic [1:0]  OV_DEB_LONG       = 2'h3;

    // ========================================================================
    // Analog scaling, in microvolts
    localparam int          OV_BASE_UV        = 750_000;
    localparam int          OV_SPAN_UV        = 750_000;
    localparam int          OV_STEPS          = 63;
    localparam int          UV_STEP_UV        = 12_500;
    localparam int          LEVEL_W           = 21;

    // ========================================================================
    // Timing: least times, rounded up to whole clock cycles
    localparam int          CLK_PERIOD_NS     = 40;
    localparam int          OV_DEB1_NS        = 960;
    localparam int          OV_DEB2_NS        = 2240;
    localparam int          OV_DEB3_NS        = 8000;
    localparam int          UV_DEB_MS         = 100;
    localparam int          OV_DEB1_CYC       =
        (OV_DEB1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          OV_DEB2_CYC       =
        (OV_DEB2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          OV_DEB3_CYC       =
        (OV_DEB3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          UV_DEB_CYC        =
        (UV_DEB_MS * 1_000_000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          DEB_W             = 22;

endpackage

/* File: verilog/fault_debounce.sv */
`timescale 1ns/1ns
module fault_debounce #(
    parameter int CNT_W = 22
) (
    input  wire logic             i_core_clk,
    input  wire logic             i_nrst,
    input  wire logic             i_cond,
    input  wire logic [CNT_W-1:0] i_limit,
    output logic                  o_flag
);

    logic [CNT_W-1:0] cnt_q;
    logic             flag_q;

    // ========================================================================
    // Run length of the condition, saturating at the limit
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cnt_q <= '0;
        end else if (!i_cond) begin
            cnt_q <= '0;
        end else if (cnt_q < i_limit) begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    // Clear is not filtered: a fault that goes away drops the flag at once
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= i_cond && (cnt_q >= i_limit);
        end
    end

    assign o_flag = flag_q;

endmodule // fault_debounce

/* File: verilog/output_fault_threshold_flags.sv */
// Function
// - Channel B overvoltage debounce field picks 0, 0.96, 2.24 or 8 us.
// - Six-bit channel B overvoltage code goes to its analog comparator.
// - Overvoltage code 0x00 means 0.75 V, code 0x3F means 1.5 V.
// - Each overvoltage code step adds 11.904 mV: code*0.75/63 + 0.75 V.
// - Channel A undervoltage bit 7 selects no debounce or 100 ms.
// - Channel B undervoltage bit 7 selects no debounce or 100 ms.
// - Channel A undervoltage flag sets when threshold exceeds sensed MSBs.
// - Channel B undervoltage flag sets when threshold exceeds sensed MSBs.
// - Each undervoltage threshold step stands for 12.5 mV.
// - A zero undervoltage threshold holds that channel's flag cleared.
`timescale 1ns/1ns
module output_fault_threshold_flags #(
    parameter int VS_W               = 12,
    parameter int UV_DEBOUNCE_CYCLES = fault_flag_pkg::UV_DEB_CYC
) (
    input  wire logic                                 i_core_clk,
    input  wire logic                                 i_nrst,
    input  wire logic                                 i_psel,
    input  wire logic                                 i_penable,
    input  wire logic                                 i_pwrite,
    input  wire logic [fault_flag_pkg::ADDR_W-1:0]    i_paddr,
    input  wire logic [31:0]                          i_pwdata,
    input  wire logic [3:0]                           i_pstrb,
    output logic      [31:0]                          o_prdata,
    output logic                                      o_pready,
    output logic                                      o_pslverr,
    input  wire logic [VS_W-1:0]                      i_chan_a_sensed_voltage,
    input  wire logic [VS_W-1:0]                      i_chan_b_sensed_voltage,
    input  wire logic                                 i_chan_b_overvoltage_cmp,
    output logic [fault_flag_pkg::OV_CODE_W-1:0]      o_chan_b_overvoltage_code,
    output logic [fault_flag_pkg::LEVEL_W-1:0]        o_chan_b_ov_trip_uv,
    output logic [fault_flag_pkg::LEVEL_W-1:0]        o_chan_a_uv_level_uv,
    output logic [fault_flag_pkg::LEVEL_W-1:0]        o_chan_b_uv_level_uv,
    output logic                                      o_chan_b_overvoltage,
    output logic                                      o_chan_a_undervoltage,
    output logic                                      o_chan_b_undervoltage,
    output logic                                      o_irq
);

    import fault_flag_pkg::*;

    localparam logic [DEB_W-1:0] UV_LIMIT = DEB_W'(UV_DEBOUNCE_CYCLES);

    logic [7:0]            ov_b_setting_q;
    logic [7:0]            uv_a_setting_q;
    logic [7:0]            uv_b_setting_q;
    logic [NUM_FLAGS-1:0]  status_q;
    logic [NUM_FLAGS-1:0]  mask_q;
    logic [NUM_FLAGS-1:0]  live_prev_q;
    logic [31:0]           prdata_q;
    logic                  ov_cmp_meta_q;
    logic                  ov_cmp_sync_q;
    logic [LEVEL_W-1:0]    ov_trip_q;
    logic [LEVEL_W-1:0]    uv_a_level_q;
    logic [LEVEL_W-1:0]    uv_b_level_q;

    logic                  setup_phase;
    logic                  access_phase;
    logic                  addr_hit;
    logic                  wr_en;
    logic                  status_rd;
    logic [UV_THR_W-1:0]   uv_a_thr;
    logic [UV_THR_W-1:0]   uv_b_thr;
    logic                  uv_a_cond;
    logic                  uv_b_cond;
    logic [DEB_W-1:0]      ov_limit;
    logic [DEB_W-1:0]      uv_a_limit;
    logic [DEB_W-1:0]      uv_b_limit;
    logic [NUM_FLAGS-1:0]  live;
    logic [NUM_FLAGS-1:0]  rise;
    logic [NUM_FLAGS-1:0]  status_clr;
    logic [NUM_FLAGS-1:0]  status_d;
    logic [31:0]           prdata_d;
    logic [LEVEL_W-1:0]    ov_trip_d;
    logic [LEVEL_W-1:0]    uv_a_level_d;
    logic [LEVEL_W-1:0]    uv_b_level_d;

    // ========================================================================
    // APB decode
    assign setup_phase  = i_psel && !i_penable;
    assign access_phase = i_psel && i_penable;

    always_comb begin
        case (i_paddr)
            ADDR_CHAN_B_OV,
            ADDR_CHAN_A_UV,
            ADDR_CHAN_B_UV,
            ADDR_FAULT_STATUS,
            ADDR_FAULT_MASK,
            ADDR_FAULT_LIVE: addr_hit = 1'b1;
            default:         addr_hit = 1'b0;
        endcase
    end

    // Zero wait states: read data is captured during the setup cycle
    assign o_pready  = access_phase;
    assign o_pslverr = access_phase && !addr_hit;
    assign wr_en     = access_phase && i_pwrite && addr_hit && i_pstrb[0];
    assign status_rd = access_phase && !i_pwrite
                       && (i_paddr == ADDR_FAULT_STATUS);

    // ========================================================================
    // Setting registers
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ov_b_setting_q <= RST_SETTING;
        end else if (wr_en && i_paddr == ADDR_CHAN_B_OV) begin
            ov_b_setting_q <= i_pwdata[7:0];
        end
    end

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            uv_a_setting_q <= RST_SETTING;
        end else if (wr_en && i_paddr == ADDR_CHAN_A_UV) begin
            uv_a_setting_q <= i_pwdata[7:0];
        end
    end

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            uv_b_setting_q <= RST_SETTING;
        end else if (wr_en && i_paddr == ADDR_CHAN_B_UV) begin
            uv_b_setting_q <= i_pwdata[7:0];
        end
    end

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            mask_q <= RST_MASK;
        end else if (wr_en && i_paddr == ADDR_FAULT_MASK) begin
            mask_q <= i_pwdata[NUM_FLAGS-1:0];
        end
    end

    // ========================================================================
    // Read data
    always_comb begin
        case (i_paddr)
            ADDR_CHAN_B_OV:    prdata_d = {24'h00_0000, ov_b_setting_q};
            ADDR_CHAN_A_UV:    prdata_d = {24'h00_0000, uv_a_setting_q};
            ADDR_CHAN_B_UV:    prdata_d = {24'h00_0000, uv_b_setting_q};
            ADDR_FAULT_STATUS: prdata_d = {29'h0000_0000, status_q};
            ADDR_FAULT_MASK:   prdata_d = {29'h0000_0000, mask_q};
            ADDR_FAULT_LIVE:   prdata_d = {29'h0000_0000, live};
            default:           prdata_d = 32'h0000_0000;
        endcase
    end

    // Captured in the setup cycle so the data stands through the access
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            prdata_q <= 32'h0000_0000;
        end else if (setup_phase && !i_pwrite) begin
            prdata_q <= prdata_d;
        end
    end

    assign o_prdata = prdata_q;

    // ========================================================================
    // Comparator synchroniser; the comparator runs off the analog clock tree
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ov_cmp_meta_q <= 1'b0;
            ov_cmp_sync_q <= 1'b0;
        end else begin
            ov_cmp_meta_q <= i_chan_b_overvoltage_cmp;
            ov_cmp_sync_q <= ov_cmp_meta_q;
        end
    end

    // ========================================================================
    // Channel B overvoltage: trip code and debounce selection
    assign o_chan_b_overvoltage_code = ov_b_setting_q[OV_CODE_W-1:0];

    always_comb begin
        case (ov_b_setting_q[OV_DEB_HI:OV_DEB_LO])
            OV_DEB_NONE:  ov_limit = '0;
            OV_DEB_SHORT: ov_limit = DEB_W'(OV_DEB1_CYC);
            OV_DEB_MID:   ov_limit = DEB_W'(OV_DEB2_CYC);
            OV_DEB_LONG:  ov_limit = DEB_W'(OV_DEB3_CYC);
            default:      ov_limit = '0;
        endcase
    end

    // Nominal trip level reported for monitoring; integer truncation
    // leaves it at most 1 uV under the ideal figure
    assign ov_trip_d = LEVEL_W'(OV_BASE_UV
        + (int'(ov_b_setting_q[OV_CODE_W-1:0]) * OV_SPAN_UV)
        / OV_STEPS);

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ov_trip_q <= LEVEL_W'(OV_BASE_UV);
        end else begin
            ov_trip_q <= ov_trip_d;
        end
    end

    assign o_chan_b_ov_trip_uv = ov_trip_q;

    fault_debounce #(
        .CNT_W      (DEB_W)
    ) u_ov_b_deb (
        .i_core_clk (i_core_clk),
        .i_nrst     (i_nrst),
        .i_cond     (ov_cmp_sync_q),
        .i_limit    (ov_limit),
        .o_flag     (o_chan_b_overvoltage)
    );

    // ========================================================================
    // Undervoltage compare against the top seven sensed-voltage bits
    assign uv_a_thr = uv_a_setting_q[UV_THR_W-1:0];
    assign uv_b_thr = uv_b_setting_q[UV_THR_W-1:0];

    // A zero threshold can never exceed the sample, so detection is off
    assign uv_a_cond = (uv_a_thr != '0)
        && (uv_a_thr
            > i_chan_a_sensed_voltage[VS_W-1 -: UV_THR_W]);
    assign uv_b_cond = (uv_b_thr != '0)
        && (uv_b_thr
            > i_chan_b_sensed_voltage[VS_W-1 -: UV_THR_W]);

    assign uv_a_limit = uv_a_setting_q[UV_DEB_BIT] ? UV_LIMIT : '0;
    assign uv_b_limit = uv_b_setting_q[UV_DEB_BIT] ? UV_LIMIT : '0;

    fault_debounce #(
        .CNT_W      (DEB_W)
    ) u_uv_a_deb (
        .i_core_clk (i_core_clk),
        .i_nrst     (i_nrst),
        .i_cond     (uv_a_cond),
        .i_limit    (uv_a_limit),
        .o_flag     (o_chan_a_undervoltage)
    );

    fault_debounce #(
        .CNT_W      (DEB_W)
    ) u_uv_b_deb (
        .i_core_clk (i_core_clk),
        .i_nrst     (i_nrst),
        .i_cond     (uv_b_cond),
        .i_limit    (uv_b_limit),
        .o_flag     (o_chan_b_undervoltage)
    );

    // Threshold levels in microvolts for telemetry
    assign uv_a_level_d = LEVEL_W'(int'(uv_a_thr) * UV_STEP_UV);
    assign uv_b_level_d = LEVEL_W'(int'(uv_b_thr) * UV_STEP_UV);

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            uv_a_level_q <= '0;
        end else begin
            uv_a_level_q <= uv_a_level_d;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            uv_b_level_q <= '0;
        end else begin
            uv_b_level_q <= uv_b_level_d;
        end
    end

    assign o_chan_a_uv_level_uv = uv_a_level_q;
    assign o_chan_b_uv_level_uv = uv_b_level_q;

    // ========================================================================
    // Sticky status and interrupt
    assign live[BIT_CHAN_B_OV] = o_chan_b_overvoltage;
    assign live[BIT_CHAN_A_UV] = o_chan_a_undervoltage;
    assign live[BIT_CHAN_B_UV] = o_chan_b_undervoltage;
    assign rise                = live & ~live_prev_q;

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            live_prev_q <= '0;
        end else begin
            live_prev_q <= live;
        end
    end

    // A read clears only the bits that it returned, so an event landing
    // between setup and access is not lost; a new edge wins the clear
    assign status_clr = status_rd ? prdata_q[NUM_FLAGS-1:0] : '0;
    assign status_d   = (status_q & ~status_clr) | rise;

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            status_q <= '0;
        end else begin
            status_q <= status_d;
        end
    end

    assign o_irq = |(status_q & mask_q);

endmodule // output_fault_threshold_flags

/* File: verif/fault_flags_monitor.sv */
`timescale 1ns/1ns
module fault_flags_monitor #(
    parameter int VS_W = 12
) (
    input wire logic                                i_core_clk,
    input wire logic                                i_nrst,
    input wire logic                                i_psel,
    input wire logic                                i_penable,
    input wire logic                                i_pwrite,
    input wire logic [fault_flag_pkg::ADDR_W-1:0]   i_paddr,
    input wire logic [31:0]                         i_pwdata,
    input wire logic [3:0]                          i_pstrb,
    input wire logic                                o_pready,
    input wire logic                                o_pslverr,
    input wire logic [VS_W-1:0]                     i_chan_a_sensed_voltage,
    input wire logic [VS_W-1:0]                     i_chan_b_sensed_voltage,
    input wire logic                                i_chan_b_overvoltage_cmp,
    input wire logic [fault_flag_pkg::OV_CODE_W-1:0] o_chan_b_overvoltage_code,
    input wire logic [fault_flag_pkg::LEVEL_W-1:0]  o_chan_b_ov_trip_uv,
    input wire logic [fault_flag_pkg::LEVEL_W-1:0]  o_chan_a_uv_level_uv,
    input wire logic [fault_flag_pkg::LEVEL_W-1:0]  o_chan_b_uv_level_uv,
    input wire logic                                o_chan_b_overvoltage,
    input wire logic                                o_chan_a_undervoltage,
    input wire logic                                o_chan_b_undervoltage
);
    import fault_flag_pkg::*;
    // ====================
    // Clocking and sequences
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_nrst);
    sequence ov_write;
        i_psel && i_penable && i_pwrite && i_pstrb[0] &&
        i_paddr == ADDR_CHAN_B_OV;
    endsequence
    // Two sync flops plus the flag register
    sequence ov_quiet;
        !i_chan_b_overvoltage_cmp [*4];
    endsequence
    // ====================
    // Properties
    ready_follows_a: assert property (o_pready == (i_psel && i_penable))
        else $error("ready does not follow the access phase");
    misalign_err_a: assert property (i_psel && i_penable &&
        i_paddr[1:0] != 2'h0 |-> o_pslverr)
        else $error("misaligned access not refused");
    ov_code_a: assert property (ov_write |=>
        o_chan_b_overvoltage_code == $past(i_pwdata[5:0]))
        else $error("channel B code not loaded");
    ov_trip_a: assert property (o_chan_b_ov_trip_uv ==
        LEVEL_W'(OV_BASE_UV + int'($past(o_chan_b_overvoltage_code)) *
        OV_SPAN_UV / OV_STEPS))
        else $error("channel B trip level wrong");
    ov_rise_a: assert property ($rose(o_chan_b_overvoltage) |->
        $past(i_chan_b_overvoltage_cmp, 3))
        else $error("overvoltage flag rose without cause");
    ov_fall_a: assert property (ov_quiet |->
        !o_chan_b_overvoltage)
        else $error("overvoltage flag stuck");
    // Level ports carry the threshold one cycle late, as the flag is
    uva_rise_a: assert property ($rose(o_chan_a_undervoltage) |->
        int'(o_chan_a_uv_level_uv) > UV_STEP_UV *
        int'($past(i_chan_a_sensed_voltage[VS_W-1:VS_W-7])))
        else $error("channel A undervoltage rose without cause");
    uvb_rise_a: assert property ($rose(o_chan_b_undervoltage) |->
        int'(o_chan_b_uv_level_uv) > UV_STEP_UV *
        int'($past(i_chan_b_sensed_voltage[VS_W-1:VS_W-7])))
        else $error("channel B undervoltage rose without cause");
    uva_zero_a: assert property (o_chan_a_uv_level_uv == '0 &&
        $past(o_chan_a_uv_level_uv) == '0 |-> !o_chan_a_undervoltage)
        else $error("channel A flag set with zero threshold");
    uvb_zero_a: assert property (o_chan_b_uv_level_uv == '0 &&
        $past(o_chan_b_uv_level_uv) == '0 |-> !o_chan_b_undervoltage)
        else $error("channel B flag set with zero threshold");
endmodule // fault_flags_monitor

bind output_fault_threshold_flags fault_flags_monitor #(.VS_W(VS_W))
    fault_flags_monitor_inst (.*);

/* File: verif/tb_output_fault_threshold_flags.sv */
`timescale 1ns/1ns
module tb_output_fault_threshold_flags;
    import fault_flag_pkg::*;
    // ====================
    // Signals
    logic                 i_core_clk = 1'b0;
    logic                 i_nrst = 1'b0;
    logic                 i_psel = 1'b0;
    logic                 i_penable = 1'b0;
    logic                 i_pwrite = 1'b0;
    logic [ADDR_W-1:0]    i_paddr = '0;
    logic [31:0]          i_pwdata = '0;
    logic [3:0]           i_pstrb = 4'h0;
    logic [11:0]          i_chan_a_sensed_voltage = 12'hfe0;
    logic [11:0]          i_chan_b_sensed_voltage = 12'hfe0;
    logic                 i_chan_b_overvoltage_cmp = 1'b0;
    logic [31:0]          o_prdata, rd;
    logic                 o_pready, o_pslverr, o_irq, err;
    logic [OV_CODE_W-1:0] o_chan_b_overvoltage_code;
    logic [LEVEL_W-1:0]   o_chan_b_ov_trip_uv;
    logic [LEVEL_W-1:0]   o_chan_a_uv_level_uv, o_chan_b_uv_level_uv;
    logic                 o_chan_b_overvoltage;
    logic                 o_chan_a_undervoltage, o_chan_b_undervoltage;
    int                   miscompares = 0;
    int                   samples_checked = 0;
    int                   lim [4] = '{0, OV_DEB1_CYC, OV_DEB2_CYC,
        OV_DEB3_CYC};
    logic [5:0]           codes [3] = '{6'h00, 6'h3f, 6'h15};
    logic [17:0]          rst_addr [5] = '{ADDR_CHAN_B_OV, ADDR_CHAN_A_UV,
        ADDR_CHAN_B_UV, ADDR_FAULT_MASK, ADDR_FAULT_STATUS};

    always #20 i_core_clk = ~i_core_clk;

    // Short debounce keeps the 100 ms cases inside the run
    localparam int        UV_CYC = 20;
    output_fault_threshold_flags #(.UV_DEBOUNCE_CYCLES(UV_CYC))
        output_fault_threshold_flags_inst (.*);

    // ====================
    // Tasks
    task automatic final_report();
        if (miscompares == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h not %h", $time, got, exp);
        end
    endtask

    task automatic check_flag(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: flag is %b", $time, got);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge i_core_clk);
    endtask

    task automatic apb(input logic w, input logic [17:0] a,
                       input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge i_core_clk);
        i_psel <= 1'b1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        i_pstrb <= s;
        @(posedge i_core_clk);
        i_penable <= 1'b1;
        do begin
            @(posedge i_core_clk);
            n++;
        end while (o_pready !== 1'b1 && n < 50);
        if (o_pready !== 1'b1) begin
            miscompares++;
            final_report();
        end
        rd = o_prdata;
        err = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask

    task automatic wr(input logic [17:0] a, input logic [7:0] d);
        apb(1'b1, a, 32'(d), 4'hf);
    endtask

    task automatic rchk(input logic [17:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000, 4'h0);
        check(rd, exp);
    endtask

    // ====================
    // Sequence
    initial begin
        tick(4);
        i_nrst <= 1'b1;
        foreach (rst_addr[k]) begin
            rchk(rst_addr[k], 32'h0000_0000);
        end
        foreach (codes[k]) begin
            wr(ADDR_CHAN_B_OV, {2'b00, codes[k]});
            rchk(ADDR_CHAN_B_OV, 32'(codes[k]));
            check(32'(o_chan_b_overvoltage_code), 32'(codes[k]));
            check(32'(o_chan_b_ov_trip_uv), OV_BASE_UV +
                codes[k] * OV_SPAN_UV / OV_STEPS);
        end
        // Disabled byte lane must leave the setting alone
        apb(1'b1, ADDR_CHAN_B_OV, 32'h0000_003f, 4'h0);
        rchk(ADDR_CHAN_B_OV, 32'h0000_0015);
        apb(1'b0, 18'h0_0010, 32'h0000_0000, 4'h0);
        check(rd, 32'h0000_0000);
        check_flag(err, 1'b1);
        apb(1'b1, ADDR_CHAN_A_UV + 18'h0_0001, 32'h0000_0055, 4'hf);
        check_flag(err, 1'b1);
        rchk(ADDR_CHAN_A_UV, 32'h0000_0000);
        foreach (lim[k]) begin
            wr(ADDR_CHAN_B_OV, {2'(k), 6'h15});
            i_chan_b_overvoltage_cmp <= 1'b1;
            tick(lim[k] + 3);
            check_flag(o_chan_b_overvoltage, 1'b0);
            tick(1);
            check_flag(o_chan_b_overvoltage, 1'b1);
            i_chan_b_overvoltage_cmp <= 1'b0;
            tick(5);
        end
        rchk(ADDR_FAULT_STATUS, 32'h0000_0001);
        wr(ADDR_CHAN_A_UV, 8'h10);
        i_chan_a_sensed_voltage <= 12'h200;
        tick(3);
        check_flag(o_chan_a_undervoltage, 1'b0);
        check(32'(o_chan_a_uv_level_uv), 16 * UV_STEP_UV);
        i_chan_a_sensed_voltage <= 12'h1e0;
        tick(2);
        check_flag(o_chan_a_undervoltage, 1'b1);
        check_flag(o_irq, 1'b0);
        wr(ADDR_FAULT_MASK, 8'h02);
        rchk(ADDR_FAULT_LIVE, 32'h0000_0002);
        check_flag(o_irq, 1'b1);
        rchk(ADDR_FAULT_STATUS, 32'h0000_0002);
        tick(2);
        check_flag(o_irq, 1'b0);
        rchk(ADDR_FAULT_STATUS, 32'h0000_0000);
        wr(ADDR_CHAN_A_UV, 8'h00);
        tick(3);
        check_flag(o_chan_a_undervoltage, 1'b0);
        wr(ADDR_CHAN_A_UV, 8'h90);
        tick(UV_CYC + 1);
        check_flag(o_chan_a_undervoltage, 1'b0);
        tick(1);
        check_flag(o_chan_a_undervoltage, 1'b1);
        check(32'(o_chan_a_uv_level_uv), 16 * UV_STEP_UV);
        wr(ADDR_CHAN_B_UV, 8'h90);
        i_chan_b_sensed_voltage <= 12'h1e0;
        tick(10);
        i_chan_b_sensed_voltage <= 12'hfe0;
        tick(15);
        check_flag(o_chan_b_undervoltage, 1'b0);
        i_chan_b_sensed_voltage <= 12'h1e0;
        tick(UV_CYC + 1);
        check_flag(o_chan_b_undervoltage, 1'b0);
        tick(1);
        check_flag(o_chan_b_undervoltage, 1'b1);
        check(32'(o_chan_b_uv_level_uv), 16 * UV_STEP_UV);
        final_report();
    end
endmodule // tb_output_fault_threshold_flags
